/* File: rtl/uart_pins_defines.vh */
/*
 Constants for the dual UART host and modem pin block.
 Assumes one 20 MHz clock and a host bus sampled through synchronisers.
*/
//Function
// - While chip select is low the host bus is joined to channel A or B by the channel pick.
// - With chip select low, channel pick low addresses channel B and high addresses channel A.
// - Alternate function bit 0 makes one host write update both channels together.
// - Modem status bit 4 reports the inverted clear-to-send input, high meaning ready for transmit data.
// - Clear-to-send gates transmit only, and only when enhanced feature bit 7 is set.
// - The host data bus is 8 bits, bit 0 least significant and first on the serial line.
// - Modem status reflects each channel's data-set-ready input, low meaning modem ready.
// - Writing one to modem control bit 0 drives that channel's terminal-ready output low.
// - Terminal-ready goes high after a zero is written to modem control bit 0 and after reset.
// - The interrupt output is enabled only by modem control bit 3, sources by interrupt enable.
// - Interrupt sources are receive errors, receive data, transmit space and modem change.
// - After reset both interrupt outputs are high impedance.
// - On the rising edge of the write strobe the data bus is latched into the addressed register.
`ifndef UART_PINS_DEFINES_VH
`define UART_PINS_DEFINES_VH
`define ADDR_IER        3'h1
`define ADDR_EFR        3'h2
`define ADDR_AFR        3'h2
`define ADDR_MCR        3'h4
`define ADDR_MSR        3'h6
`define MCR_DTR_BIT     0
`define MCR_IRQ_EN_BIT  3
`define MSR_DCTS_BIT    0
`define MSR_DDSR_BIT    1
`define MSR_CTS_BIT     4
`define MSR_DSR_BIT     5
`define EFR_AUTO_CTS_BIT 7
`define AFR_BOTH_BIT    0
`define IER_RX_BIT      0
`define IER_TX_BIT      1
`define IER_LS_BIT      2
`define IER_MS_BIT      3
`define RST_MCR         8'h00
`define RST_IER         8'h00
`define RST_EFR         8'h00
`define RST_AFR         8'h00
`endif

/* File: rtl/uart_chan_regs.v */
/*
 One channel's modem control, interrupt enable, feature and status logic.
 Assumes write pulses and modem levels already synchronised to ref_clk.
*/
`timescale 1ns/1ps
`include "uart_pins_defines.vh"
module uart_chan_regs (
    input  wire       ref_clk,
    input  wire       srst,
    input  wire       wr_pulse,
    input  wire       rd_msr_pulse,
    input  wire       efr_space,
    input  wire [2:0] addr,
    input  wire [7:0] wdata,
    input  wire       cts_n,
    input  wire       dsr_n,
    input  wire       rx_err,
    input  wire       rx_avail,
    input  wire       tx_space,
    output wire [7:0] modem_status_reg,
    output wire       dtr_n,
    output wire       irq,
    output wire       irq_oe_n,
    output wire       tx_allow
);
    reg [7:0] mcr_q;
    reg [7:0] ier_q;
    reg [7:0] efr_q;
    reg       cts_q;
    reg       dsr_q;
    reg       dcts_q;
    reg       ddsr_q;
    reg       irq_q;
    wire      ms_change;
    wire      src;

    assign ms_change = (cts_q != ~cts_n) | (dsr_q != ~dsr_n);

    always @(posedge ref_clk) begin
        if (srst) begin
            mcr_q  <= `RST_MCR;
            ier_q  <= `RST_IER;
            efr_q  <= `RST_EFR;
            cts_q  <= 1'b0;
            dsr_q  <= 1'b0;
            dcts_q <= 1'b0;
            ddsr_q <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            if (wr_pulse) begin
                if (addr == `ADDR_MCR)
                    mcr_q <= wdata;
                if (addr == `ADDR_IER)
                    ier_q <= wdata;
                if (addr == `ADDR_EFR && efr_space)
                    efr_q <= wdata;
            end
            cts_q <= ~cts_n;
            dsr_q <= ~dsr_n;
            // Delta flags: set wins over read clear
            dcts_q <= (cts_q != ~cts_n) | (dcts_q & ~rd_msr_pulse);
            ddsr_q <= (dsr_q != ~dsr_n) | (ddsr_q & ~rd_msr_pulse);
            irq_q  <= src;
        end
    end

    assign src = (ier_q[`IER_LS_BIT] & rx_err) | (ier_q[`IER_RX_BIT] & rx_avail)
               | (ier_q[`IER_TX_BIT] & tx_space)
               | (ier_q[`IER_MS_BIT] & (dcts_q | ddsr_q | ms_change));

    assign modem_status_reg = {2'b00, dsr_q, cts_q, 2'b00, ddsr_q, dcts_q};
    assign dtr_n = ~mcr_q[`MCR_DTR_BIT];
    assign irq = irq_q & mcr_q[`MCR_IRQ_EN_BIT];
    assign irq_oe_n = ~mcr_q[`MCR_IRQ_EN_BIT];
    assign tx_allow = ~efr_q[`EFR_AUTO_CTS_BIT] | ~cts_n;
endmodule

/* File: rtl/dual_uart_pins.v */
/*
 Dual UART host bus and modem pin logic for channels A and B.
 Assumes host strobes and modem pins are asynchronous and pass three flops.
*/
`timescale 1ns/1ps
`include "uart_pins_defines.vh"
module dual_uart_pins (
    input  wire       ref_clk,
    input  wire       srst,
    input  wire       cs_n,
    input  wire       channel_pick,
    input  wire [2:0] addr,
    input  wire [7:0] data_in,
    output reg  [7:0] data_out,
    output wire       data_oe_n,
    input  wire       write_strobe_n,
    input  wire       read_strobe_n,
    input  wire       efr_space,
    input  wire       both_en,
    input  wire [1:0] cts_n,
    input  wire [1:0] dsr_n,
    output wire [1:0] dtr_n,
    input  wire [1:0] rx_err,
    input  wire [1:0] rx_avail,
    input  wire [1:0] tx_space,
    output wire       irq_channel_a,
    output wire       irq_channel_a_oe_n,
    output wire       irq_channel_b,
    output wire       irq_channel_b_oe_n,
    output wire [1:0] tx_allow
);
    // Three-stage synchronisers, index 0 A, 1 B
    reg [2:0]  wr_s;
    reg [2:0]  rd_s;
    reg [2:0]  cs_s;
    reg [2:0]  pk_s;
    reg [2:0]  cts_a_s;
    reg [2:0]  cts_b_s;
    reg [2:0]  dsr_a_s;
    reg [2:0]  dsr_b_s;
    reg        wr_st_q;
    reg        rd_st_q;
    reg        cts_st_q_a;
    reg        cts_st_q_b;
    reg        dsr_st_q_a;
    reg        dsr_st_q_b;
    reg        afr_both_q;
    reg [7:0]  wd_q;
    reg [2:0]  ad_q;
    reg        pick_q;
    reg        sel_q;
    wire [7:0] msr_a;
    wire [7:0] msr_b;
    wire       wr_now;
    wire       rd_now;
    wire       wr_rise;
    wire       rd_fall;
    wire       cs_ok;
    wire       pick_ok;
    wire       wr_a;
    wire       wr_b;

    always @(posedge ref_clk) begin
        if (srst) begin
            wr_s <= 3'h7;
            rd_s <= 3'h7;
            cs_s <= 3'h7;
            pk_s <= 3'h7;
            cts_a_s <= 3'h7;
            cts_b_s <= 3'h7;
            dsr_a_s <= 3'h7;
            dsr_b_s <= 3'h7;
        end else begin
            wr_s <= {wr_s[1:0], write_strobe_n};
            rd_s <= {rd_s[1:0], read_strobe_n};
            cs_s <= {cs_s[1:0], cs_n};
            pk_s <= {pk_s[1:0], channel_pick};
            // One chain per pin keeps channel A and B apart
            cts_a_s <= {cts_a_s[1:0], cts_n[0]};
            cts_b_s <= {cts_b_s[1:0], cts_n[1]};
            dsr_a_s <= {dsr_a_s[1:0], dsr_n[0]};
            dsr_b_s <= {dsr_b_s[1:0], dsr_n[1]};
        end
    end

    // A change counts once stages two and three agree
    assign wr_now  = (wr_s[1] == wr_s[2]) ? wr_s[2] : wr_st_q;
    assign rd_now  = (rd_s[1] == rd_s[2]) ? rd_s[2] : rd_st_q;
    assign cs_ok   = (cs_s[1] == cs_s[2]) ? ~cs_s[2] : 1'b0;
    assign pick_ok = (pk_s[1] == pk_s[2]) ? pk_s[2] : pick_q;
    assign wr_rise = wr_now & ~wr_st_q;
    assign rd_fall = ~rd_now & rd_st_q;

    always @(posedge ref_clk) begin
        if (srst) begin
            wr_st_q <= 1'b1;
            rd_st_q <= 1'b1;
            cts_st_q_a <= 1'b1;
            cts_st_q_b <= 1'b1;
            dsr_st_q_a <= 1'b1;
            dsr_st_q_b <= 1'b1;
            afr_both_q <= 1'b0;
            wd_q <= 8'h00;
            ad_q <= 3'h0;
            pick_q <= 1'b1;
            sel_q <= 1'b0;
            data_out <= 8'h00;
        end else begin
            wr_st_q <= wr_now;
            rd_st_q <= rd_now;
            pick_q <= pick_ok;
            if (cts_a_s[1] == cts_a_s[2]) cts_st_q_a <= cts_a_s[2];
            if (cts_b_s[1] == cts_b_s[2]) cts_st_q_b <= cts_b_s[2];
            if (dsr_a_s[1] == dsr_a_s[2]) dsr_st_q_a <= dsr_a_s[2];
            if (dsr_b_s[1] == dsr_b_s[2]) dsr_st_q_b <= dsr_b_s[2];
            // Capture data and address while strobe is low
            if (~wr_now & cs_ok) begin
                wd_q <= data_in;
                ad_q <= addr;
                sel_q <= pick_ok;
            end
            if (wr_rise & cs_ok & ad_q == `ADDR_AFR & both_en)
                afr_both_q <= wd_q[`AFR_BOTH_BIT];
            if (rd_fall & cs_ok & addr == `ADDR_MSR)
                data_out <= pick_ok ? msr_a : msr_b;
        end
    end

    assign data_oe_n = ~(cs_ok & ~rd_now);
    assign wr_a = wr_rise & cs_ok & (sel_q | afr_both_q);
    assign wr_b = wr_rise & cs_ok & (~sel_q | afr_both_q);

    uart_chan_regs u_chan_a (
        .ref_clk      (ref_clk),
        .srst         (srst),
        .wr_pulse     (wr_a),
        .rd_msr_pulse (rd_fall & cs_ok & pick_ok & addr == `ADDR_MSR),
        .efr_space    (efr_space),
        .addr         (ad_q),
        .wdata        (wd_q),
        .cts_n        (cts_st_q_a),
        .dsr_n        (dsr_st_q_a),
        .rx_err       (rx_err[0]),
        .rx_avail     (rx_avail[0]),
        .tx_space     (tx_space[0]),
        .modem_status_reg          (msr_a),
        .dtr_n        (dtr_n[0]),
        .irq          (irq_channel_a),
        .irq_oe_n     (irq_channel_a_oe_n),
        .tx_allow     (tx_allow[0])
    );

    uart_chan_regs u_chan_b (
        .ref_clk      (ref_clk),
        .srst         (srst),
        .wr_pulse     (wr_b),
        .rd_msr_pulse (rd_fall & cs_ok & ~pick_ok & addr == `ADDR_MSR),
        .efr_space    (efr_space),
        .addr         (ad_q),
        .wdata        (wd_q),
        .cts_n        (cts_st_q_b),
        .dsr_n        (dsr_st_q_b),
        .rx_err       (rx_err[1]),
        .rx_avail     (rx_avail[1]),
        .tx_space     (tx_space[1]),
        .modem_status_reg          (msr_b),
        .dtr_n        (dtr_n[1]),
        .irq          (irq_channel_b),
        .irq_oe_n     (irq_channel_b_oe_n),
        .tx_allow     (tx_allow[1])
    );
endmodule

/* File: tb/uart_pins_assertions.sv */
/*
 Port checker for dual_uart_pins.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module uart_pins_assertions (
    input wire       ref_clk,
    input wire       srst,
    input wire       cs_n,
    input wire       read_strobe_n,
    input wire       write_strobe_n,
    input wire [1:0] cts_n,
    input wire [1:0] dtr_n,
    input wire       data_oe_n,
    input wire       irq_channel_a,
    input wire       irq_channel_a_oe_n,
    input wire       irq_channel_b,
    input wire       irq_channel_b_oe_n,
    input wire [1:0] tx_allow
);
    reg [3:0] wr_age_q;
    reg [3:0] rd_age_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Cycles since a write strobe or a selected read was low
    always @(posedge ref_clk) begin
        if (srst)
            wr_age_q <= 4'hf;
        else if (!write_strobe_n)
            wr_age_q <= 4'h0;
        else if (wr_age_q != 4'hf)
            wr_age_q <= wr_age_q + 4'h1;
        if (srst)
            rd_age_q <= 4'hf;
        else if (!read_strobe_n && !cs_n)
            rd_age_q <= 4'h0;
        else if (rd_age_q != 4'hf)
            rd_age_q <= rd_age_q + 4'h1;
    end
    AST_RST_HIZ: assert property (disable iff (1'b0) srst |=> irq_channel_a_oe_n && irq_channel_b_oe_n)
        else $error("interrupt pins driven after reset");
    AST_RST_DTR: assert property (disable iff (1'b0) srst |=> dtr_n == 2'h3)
        else $error("terminal ready low after reset");
    AST_IRQA_OE: assert property (irq_channel_a |-> !irq_channel_a_oe_n)
        else $error("interrupt A high while not driven");
    AST_IRQB_OE: assert property (irq_channel_b |-> !irq_channel_b_oe_n)
        else $error("interrupt B high while not driven");
    AST_DTR_WR: assert property (!$stable(dtr_n) |-> wr_age_q < 4'h8)
        else $error("terminal ready changed without a write");
    AST_OE_WR: assert property (!$stable(irq_channel_a_oe_n) |-> wr_age_q < 4'h8)
        else $error("interrupt enable changed without a write");
    AST_RD_OE: assert property (!data_oe_n |-> rd_age_q < 4'h6)
        else $error("data bus driven without a selected read");
    AST_IDLE_OE: assert property (read_strobe_n [*8] |-> data_oe_n)
        else $error("data bus driven while idle");
    AST_CTS: assert property ((!cts_n[0]) [*6] |-> tx_allow[0])
        else $error("transmit held while clear to send");
    cover property ($fell(dtr_n[0]));
    cover property ($rose(irq_channel_b));
    cover property ($fell(data_oe_n));
endmodule

/* File: tb/modem_model.sv */
/*
 Modem on the far side of both channels.
 Assumes the bench picks clear-to-send; data-set-ready follows terminal-ready.
*/
`timescale 1ns/1ps
module modem_model (
    input  wire       ref_clk,
    input  wire [1:0] dtr_n,
    input  wire [1:0] want_cts_n,
    output reg  [1:0] cts_n,
    output reg  [1:0] dsr_n
);
    initial begin
        cts_n = 2'h3;
        dsr_n = 2'h3;
        forever @(negedge ref_clk) begin
            cts_n <= want_cts_n;
            dsr_n <= dtr_n;
        end
    end
endmodule

/* File: tb/tb_top.sv */
/*
 Self-checking bench for dual_uart_pins with a modem model.
 Assumes a 50 ns clock; inputs change on its falling edge.
*/
`timescale 1ns/1ps
module tb_top;
    reg        ref_clk = 0, srst = 1, cs_n = 1, pick = 0, wn = 1, rn = 1, efr_space = 0;
    reg        both = 0;
    reg  [1:0] dcf = 2'h0, ddf = 2'h0;
    reg  [2:0] addr = 3'h0;
    reg  [7:0] din = 8'h00, v;
    reg  [7:0] modem_control_reg [0:1];
    reg  [1:0] want = 2'h3, rx_err = 2'h0, rx_avail = 2'h0, tx_space = 2'h0;
    wire [7:0] dout;
    wire [1:0] cts_n, dsr_n, dtr_n, txa;
    wire       doe, ia, iao, ib, ibo;
    integer    n_errors = 0, comparisons = 0, i, c;
    dual_uart_pins uut (.ref_clk(ref_clk), .srst(srst), .cs_n(cs_n), .channel_pick(pick),
        .addr(addr), .data_in(din), .data_out(dout), .data_oe_n(doe), .write_strobe_n(wn),
        .read_strobe_n(rn), .efr_space(efr_space), .both_en(both), .cts_n(cts_n), .dsr_n(dsr_n),
        .dtr_n(dtr_n), .rx_err(rx_err), .rx_avail(rx_avail), .tx_space(tx_space),
        .irq_channel_a(ia), .irq_channel_a_oe_n(iao), .irq_channel_b(ib),
        .irq_channel_b_oe_n(ibo), .tx_allow(txa));
    modem_model modem (.ref_clk(ref_clk), .dtr_n(dtr_n), .want_cts_n(want), .cts_n(cts_n),
        .dsr_n(dsr_n));
    initial forever #25 ref_clk = ~ref_clk;
    task cyc(input integer k);
        repeat (k) @(negedge ref_clk);
    endtask
    task chk(input string name, input [7:0] exp, input [7:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("errors %0d comparisons %0d", n_errors, comparisons);
            if (n_errors == 0 && comparisons > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Strobe held low and high long enough for the synchronisers
    task access(input integer ch, input [2:0] a, input [7:0] d, input rd);
        begin
            cs_n = 0;
            pick = (ch == 0);
            addr = a;
            din = d;
            if (rd) rn = 0; else wn = 0;
            cyc(6);
            if (rd) chk("data_oe_n", 8'h00, doe);
            v = dout;
            rn = 1;
            wn = 1;
            cyc(6);
            cs_n = 1;
            cyc(1);
        end
    endtask
    initial begin
        i = $urandom(9);
        modem_control_reg[0] = 8'h00;
        modem_control_reg[1] = 8'h00;
        cyc(8);
        srst = 0;
        cyc(1);
        chk("dtr_n", 8'h03, dtr_n);
        chk("irq_oe_n", 8'h03, {ibo, iao});
        for (i = 0; i < 8; i = i + 1) begin
            c = $urandom % 2;
            v = $urandom;
            ddf[c] = ddf[c] | (v[0] ^ modem_control_reg[c][0]);
            modem_control_reg[c] = v;
            access(c, 3'h4, modem_control_reg[c], 0);
            chk("dtr_n", {6'h0, ~modem_control_reg[1][0], ~modem_control_reg[0][0]}, dtr_n);
            chk("irq_oe_n", {6'h0, ~modem_control_reg[1][3], ~modem_control_reg[0][3]}, {ibo, iao});
            v = $urandom;
            dcf = dcf | (want ^ v[1:0]);
            want = v[1:0];
            cyc(4);
            access(c, 3'h6, 8'h00, 1);
            chk("msr", {2'h0, modem_control_reg[c][0], ~want[c], 2'h0, ddf[c], dcf[c]}, v & 8'h33);
            dcf[c] = 1'b0;
            ddf[c] = 1'b0;
        end
        for (i = 0; i < 3; i = i + 1) begin
            c = i % 2;
            access(c, 3'h4, 8'h08, 0);
            access(c, 3'h1, 8'h01 << i, 0);
            {rx_err[c], tx_space[c], rx_avail[c]} = 3'h1 << i;
            cyc(3);
            chk("irq", 8'h01, c ? ib : ia);
            access(c, 3'h4, 8'h00, 0);
            chk("irq", 8'h00, c ? ib : ia);
            access(c, 3'h1, 8'h00, 0);
            {rx_err[c], tx_space[c], rx_avail[c]} = 3'h0;
        end
        // Modem status source: clear old deltas, then toggle clear-to-send
        access(0, 3'h4, 8'h08, 0);
        access(0, 3'h6, 8'h00, 1);
        access(0, 3'h1, 8'h08, 0);
        chk("irq", 8'h00, ia);
        want[0] = ~want[0];
        cyc(8);
        chk("irq", 8'h01, ia);
        access(0, 3'h6, 8'h00, 1);
        chk("irq", 8'h00, ia);
        efr_space = 1;
        want = 2'h3;
        access(1, 3'h2, 8'h80, 0);
        chk("tx_allow", 8'h01, txa);
        access(1, 3'h2, 8'h00, 0);
        chk("tx_allow", 8'h03, txa);
        efr_space = 0;
        both = 1;
        access(0, 3'h2, 8'h01, 0);
        both = 0;
        access(1, 3'h4, 8'h01, 0);
        chk("dtr_n", 8'h00, dtr_n);
        srst = 1;
        cyc(4);
        srst = 0;
        cyc(1);
        chk("dtr_n", 8'h03, dtr_n);
        chk("irq_oe_n", 8'h03, {ibo, iao});
        access(1, 3'h4, 8'h01, 0);
        chk("dtr_n", 8'h01, dtr_n);
        wrap_up;
    end
    initial begin
        #200000;
        n_errors = n_errors + 1;
        wrap_up;
    end
endmodule
bind dual_uart_pins uart_pins_assertions chk_i (.ref_clk(ref_clk), .srst(srst), .cs_n(cs_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .cts_n(cts_n),
    .dtr_n(dtr_n), .data_oe_n(data_oe_n), .irq_channel_a(irq_channel_a),
    .irq_channel_a_oe_n(irq_channel_a_oe_n), .irq_channel_b(irq_channel_b),
    .irq_channel_b_oe_n(irq_channel_b_oe_n), .tx_allow(tx_allow));
